// ### rtl/irq_prio_pkg.sv
package irq_prio_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] OFS_PEND_LO = 8'h00;
  localparam logic [7:0] OFS_PEND_HI = 8'h04;
  localparam logic [7:0] OFS_MASK_LO = 8'h08;
  localparam logic [7:0] OFS_MASK_HI = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_SLOT_TYPE = 8'h14;
  localparam logic [7:0] OFS_XMAP = 8'h18;
  localparam logic [7:0] OFS_YMAP = 8'h1C;
  localparam logic [7:0] OFS_LO_VEC = 8'h20;
  localparam logic [7:0] OFS_HI_VEC = 8'h24;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CFG_TOP_LSB = 0;
  localparam int CFG_SPREAD_LSB = 8;
  localparam int CFG_TOP_SOURCE_OUTPUT_SELECT_LSB = 16;
  localparam logic [5:0] TOP_RST = 6'h1C;
  localparam logic [11:0] MAP_RST = 12'h688;
  localparam logic [1:0] OUT_LOW = 2'h0;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [5:0] VEC_NONE = 6'h00;
  localparam logic [63:0] SRC_PRESENT = 64'h00000F1F_1E32FC0E;

  // ****************************************
  // Priority table positions
  // ****************************************
  localparam logic [6:0] POS_NONE = 7'h00;
  localparam logic [6:0] POS_TOP = 7'h01;
  localparam logic [6:0] POS_MIX = 7'h02;
  localparam logic [6:0] POS_MIX_UP = 7'h1A;
  localparam logic [6:0] POS_X_GRP = 7'h07;
  localparam logic [6:0] POS_Y_GRP = 7'h15;
  localparam logic [6:0] POS_W_GRP = 7'h23;
  localparam logic [6:0] POS_Z_GRP = 7'h31;
  localparam logic [6:0] POS_X_SPR = 7'h3C;
  localparam logic [6:0] POS_Y_SPR = 7'h3D;
  localparam logic [6:0] POS_W_SPR = 7'h3F;
  localparam logic [6:0] POS_Z_SPR = 7'h40;
  localparam logic [6:0] POS_STEP = 7'h09;

  typedef enum logic [2:0] {
    FAM_NONE = 3'b000,
    FAM_MIX = 3'b001,
    FAM_X = 3'b010,
    FAM_Y = 3'b011,
    FAM_W = 3'b100,
    FAM_Z = 3'b101
  } fam_t;

  // Fixed sources sit in w, z and mixed slots; channels are mapped.
  function automatic logic [5:0] fixed_slot(input logic [5:0] n);
    logic [5:0] s;
    s = {FAM_NONE, 3'h0};
    unique case (n)
      6'h0A: s = {FAM_W, 3'h0};
      6'h0B: s = {FAM_W, 3'h1};
      6'h0C: s = {FAM_W, 3'h2};
      6'h0D: s = {FAM_W, 3'h3};
      6'h0E: s = {FAM_W, 3'h4};
      6'h0F: s = {FAM_W, 3'h5};
      6'h24: s = {FAM_W, 3'h6};
      6'h02: s = {FAM_W, 3'h7};
      6'h01: s = {FAM_Z, 3'h0};
      6'h03: s = {FAM_Z, 3'h1};
      6'h11: s = {FAM_Z, 3'h2};
      6'h14: s = {FAM_Z, 3'h3};
      6'h15: s = {FAM_Z, 3'h4};
      6'h19: s = {FAM_Z, 3'h5};
      6'h1A: s = {FAM_Z, 3'h6};
      6'h1B: s = {FAM_Z, 3'h7};
      6'h1C: s = {FAM_MIX, 3'h0};
      default: s = {FAM_NONE, 3'h0};
    endcase
    return s;
  endfunction : fixed_slot

endpackage : irq_prio_pkg

// ### rtl/arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  logic [63:0] req_vec;
  logic [5:0] top_sel;
  logic [1:0] top_source_output_select;
  logic [3:0] spread;
  logic [15:0] slot_type;
  logic [11:0] xmap;
  logic [11:0] ymap;
  logic [5:0] lo_code;
  logic [5:0] hi_code;
  modport ctrl(output req_vec, top_sel, top_source_output_select, spread, slot_type, xmap,
    ymap, input lo_code, hi_code);
  modport arb(input req_vec, top_sel, top_source_output_select, spread, slot_type, xmap,
    ymap, output lo_code, hi_code);
endinterface : arb_if
`default_nettype wire

// ### rtl/irq_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
  import irq_prio_pkg::*;
(
  // Configuration in, winners out
  arb_if.arb a
);

  function automatic logic [6:0] grp_pos(input logic [6:0] base,
    input logic [2:0] idx);
    return idx[2] ? 7'(base + 7'(idx) + 7'h01) : 7'(base + 7'(idx));
  endfunction : grp_pos

  // The last spread slot sits one position closer than the step gives.
  function automatic logic [6:0] spr_pos(input logic [6:0] base,
    input logic [2:0] idx);
    logic [6:0] p;
    p = 7'(base + 7'(7'(idx) * POS_STEP));
    return (idx == 3'h7) ? 7'(p - 7'h01) : p;
  endfunction : spr_pos

  function automatic logic [6:0] slot_pos(input logic [5:0] s,
    input logic [3:0] sp);
    logic [6:0] p;
    logic [2:0] k;
    p = POS_NONE;
    k = s[2:0];
    unique case (fam_t'(s[5:3]))
      FAM_MIX: p = 7'((k[2] ? POS_MIX_UP : POS_MIX) + 7'(k));
      FAM_X: p = sp[0] ? spr_pos(POS_X_SPR, k) : grp_pos(POS_X_GRP, k);
      FAM_Y: p = sp[1] ? spr_pos(POS_Y_SPR, k) : grp_pos(POS_Y_GRP, k);
      FAM_W: p = sp[2] ? spr_pos(POS_W_SPR, k) : grp_pos(POS_W_GRP, k);
      FAM_Z: p = sp[3] ? spr_pos(POS_Z_SPR, k) : grp_pos(POS_Z_GRP, k);
      default: p = POS_NONE;
    endcase
    return p;
  endfunction : slot_pos

  // Only the first two slots of x, y, w and z may reach the high output.
  function automatic logic slot_high(input logic [5:0] s,
    input logic [15:0] ty);
    logic [2:0] off;
    off = 3'(s[5:3] - FAM_X);
    if (s[5:3] < FAM_X || s[5:3] > FAM_Z || s[2:1] != 2'h0) begin
      return 1'b0;
    end
    return ty[{off[1:0], s[0], 1'b0} +: 2] == OUT_HIGH;
  endfunction : slot_high

  // Lowest position wins; a duplicated slot falls to the lower number.
  function automatic logic [5:0] pick(input logic [63:0] req,
    input logic [63:0][6:0] rank);
    logic [6:0] best;
    logic [5:0] win;
    best = 7'h7F;
    win = VEC_NONE;
    for (int i = 0; i < 64; i++) begin
      if (req[i] && rank[i] != POS_NONE && rank[i] < best) begin
        best = rank[i];
        win = 6'(i);
      end
    end
    return win;
  endfunction : pick

  logic [63:0][6:0] rank;
  logic [63:0] to_high;

  for (genvar i = 0; i < 64; i++) begin : g_src
    localparam logic [5:0] NUM = 6'(i);
    wire [5:0] slot;
    wire is_top;
    if (i >= 32 && i < 36) begin : g_x
      assign slot = {FAM_X, a.xmap[3*(i-32) +: 3]};
    end else if (i >= 40 && i < 44) begin : g_y
      assign slot = {FAM_Y, a.ymap[3*(i-40) +: 3]};
    end else begin : g_fix
      assign slot = fixed_slot(NUM);
    end
    assign is_top = SRC_PRESENT[i] && (NUM == a.top_sel);
    assign rank[i] = is_top ? POS_TOP : slot_pos(slot, a.spread);
    assign to_high[i] = is_top ? (a.top_source_output_select == OUT_HIGH)
                               : slot_high(slot, a.slot_type);
  end

  assign a.lo_code = pick(a.req_vec & ~to_high, rank);
  assign a.hi_code = pick(a.req_vec & to_high, rank);

endmodule : irq_arbiter
`default_nettype wire

// ### rtl/irq_prio_vec.sv
// Contract
// - Separate software mask bit per source.
// - Drive distinct high and low request outputs.
// - Requesting source sets its pending bit.
// - Each output has its own vector register.
// - All sources may use low; subset high.
// - Fixed table positions 1 to 126.
// - Grouped slots at documented positions.
// - Spread slots start 60, step nine.
// - Channels map to x or y slots.
// - Selected top source served before all others.
// - Top source selection changes take effect immediately.
// - Mask one forwards, zero blocks request.
// - Masked source still sets pending bit.
// - Peripherals apply event masks before combining.
// - Vector read returns top unmasked pending source.
// - Idle vector is zero; codes fixed.
// - Top source output select: 00 low, 10 high.
// - Only first two slots configurable high.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_vec
  import irq_prio_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Peripheral requests, indexed by vector code
  input wire logic [63:0] src_req,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  // Requests toward the system controller
  output var logic irq_lo_ff,
  output var logic irq_hi_ff,
  output var logic [5:0] lo_vec_ff,
  output var logic [5:0] hi_vec_ff
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic wait_ff;
  logic [31:0] rdata_ff;
  // Read answer source, decoded with the registers further down.
  wire [31:0] rd_mux;
  wire req = avs_read | avs_write;
  wire wr_go = ce & avs_write & ~wait_ff;

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // One wait cycle gives every read a registered, stable answer.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      wait_ff <= ~(req & wait_ff);
      if (avs_read && wait_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [63:0] pend_ff;
  logic [63:0] mask_ff;
  logic [5:0] top_sel_ff;
  logic [3:0] spread_ff;
  logic [1:0] top_source_output_select_ff;
  logic [15:0] slot_type_ff;
  logic [11:0] xmap_ff;
  logic [11:0] ymap_ff;

  wire sel_pend_lo = avs_address == OFS_PEND_LO;
  wire sel_pend_hi = avs_address == OFS_PEND_HI;
  wire sel_mask_lo = avs_address == OFS_MASK_LO;
  wire sel_mask_hi = avs_address == OFS_MASK_HI;
  wire sel_cfg = avs_address == OFS_CFG;
  wire sel_type = avs_address == OFS_SLOT_TYPE;
  wire sel_xmap = avs_address == OFS_XMAP;
  wire sel_ymap = avs_address == OFS_YMAP;
  wire sel_lo_vec = avs_address == OFS_LO_VEC;
  wire sel_hi_vec = avs_address == OFS_HI_VEC;

  wire [31:0] cfg_word = {14'h0000, top_source_output_select_ff, 4'h0, spread_ff, 2'h0,
    top_sel_ff};

  // Unmapped offsets read as zero.
  assign rd_mux =
    sel_pend_lo ? pend_ff[31:0] :
    sel_pend_hi ? pend_ff[63:32] :
    sel_mask_lo ? mask_ff[31:0] :
    sel_mask_hi ? mask_ff[63:32] :
    sel_cfg ? cfg_word :
    sel_type ? {16'h0000, slot_type_ff} :
    sel_xmap ? {20'h00000, xmap_ff} :
    sel_ymap ? {20'h00000, ymap_ff} :
    sel_lo_vec ? {26'h0000000, lo_vec_ff} :
    sel_hi_vec ? {26'h0000000, hi_vec_ff} : 32'h0000_0000;

  // Inputs are already the peripherals' event-masked, combined requests.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_ff <= 64'h0000_0000_0000_0000;
    end else if (ce) begin
      pend_ff <= src_req & SRC_PRESENT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_ff <= 64'h0000_0000_0000_0000;
    end else if (wr_go && sel_mask_lo) begin
      mask_ff[31:0] <= avs_writedata & SRC_PRESENT[31:0];
    end else if (wr_go && sel_mask_hi) begin
      mask_ff[63:32] <= avs_writedata & SRC_PRESENT[63:32];
    end
  end

  // Top source may be rewritten at any time.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      top_sel_ff <= TOP_RST;
      top_source_output_select_ff <= OUT_LOW;
    end else if (wr_go && sel_cfg) begin
      top_sel_ff <= avs_writedata[CFG_TOP_LSB +: 6];
      top_source_output_select_ff <= avs_writedata[CFG_TOP_SOURCE_OUTPUT_SELECT_LSB +: 2];
    end
  end

  // Placement has no glitch guard: software changes it only while idle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spread_ff <= 4'h0;
    end else if (wr_go && sel_cfg) begin
      spread_ff <= avs_writedata[CFG_SPREAD_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot_type_ff <= 16'h0000;
      xmap_ff <= MAP_RST;
      ymap_ff <= MAP_RST;
    end else if (wr_go) begin
      if (sel_type) begin
        slot_type_ff <= avs_writedata[15:0];
      end
      if (sel_xmap) begin
        xmap_ff <= avs_writedata[11:0];
      end
      if (sel_ymap) begin
        ymap_ff <= avs_writedata[11:0];
      end
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  arb_if arb ();

  assign arb.req_vec = pend_ff & mask_ff;
  assign arb.top_sel = top_sel_ff;
  assign arb.top_source_output_select = top_source_output_select_ff;
  assign arb.spread = spread_ff;
  assign arb.slot_type = slot_type_ff;
  assign arb.xmap = xmap_ff;
  assign arb.ymap = ymap_ff;

  irq_arbiter u_arb (
    .a(arb.arb)
  );

  // Winners are registered every enabled cycle; code zero means idle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lo_vec_ff <= VEC_NONE;
      hi_vec_ff <= VEC_NONE;
      irq_lo_ff <= 1'b0;
      irq_hi_ff <= 1'b0;
    end else if (ce) begin
      lo_vec_ff <= arb.lo_code;
      hi_vec_ff <= arb.hi_code;
      irq_lo_ff <= arb.lo_code != VEC_NONE;
      irq_hi_ff <= arb.hi_code != VEC_NONE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [63:0] req_q_ff;
  logic [5:0] top_q_ff;
  logic [1:0] top_source_output_select_q_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_q_ff <= 64'h0000_0000_0000_0000;
      top_q_ff <= TOP_RST;
      top_source_output_select_q_ff <= OUT_LOW;
    end else if (ce) begin
      req_q_ff <= arb.req_vec;
      top_q_ff <= top_sel_ff;
      top_source_output_select_q_ff <= top_source_output_select_ff;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_PEND_FOLLOWS: assert property (
    $past(ce) && !$past(rst) |-> pend_ff == $past(src_req & SRC_PRESENT))
    else $error("Pending bits do not follow requests.");

  AST_MASKED_PENDS: assert property (
    $past(ce) && !$past(rst) &&
    ($past(src_req & SRC_PRESENT & ~mask_ff) != 64'h0)
    |-> (pend_ff & ~$past(mask_ff)) != 64'h0)
    else $error("Masked request did not set its pending bit.");

  AST_IDLE_ZERO: assert property (
    req_q_ff == 64'h0 |-> !irq_lo_ff && !irq_hi_ff &&
    lo_vec_ff == VEC_NONE && hi_vec_ff == VEC_NONE)
    else $error("Output active with nothing unmasked pending.");

  AST_IRQ_TRACKS_VEC: assert property (
    irq_lo_ff == (lo_vec_ff != VEC_NONE) &&
    irq_hi_ff == (hi_vec_ff != VEC_NONE))
    else $error("Request output disagrees with its vector.");

  AST_LO_PENDING: assert property (
    lo_vec_ff != VEC_NONE |-> req_q_ff[lo_vec_ff])
    else $error("Low vector names a source not pending.");

  AST_HI_PENDING: assert property (
    hi_vec_ff != VEC_NONE |-> req_q_ff[hi_vec_ff])
    else $error("High vector names a source not pending.");

  AST_TOP_LOW: assert property (
    req_q_ff[top_q_ff] && top_source_output_select_q_ff != OUT_HIGH |-> lo_vec_ff == top_q_ff)
    else $error("Top source lost on the low output.");

  AST_TOP_HIGH: assert property (
    req_q_ff[top_q_ff] && top_source_output_select_q_ff == OUT_HIGH |-> hi_vec_ff == top_q_ff)
    else $error("Top source lost on the high output.");

  AST_TOP_LIVE: assert property (
    wr_go && sel_cfg |=> top_sel_ff == $past(avs_writedata[5:0]))
    else $error("Top source rewrite not applied.");

  AST_HIGH_NEEDS_CFG: assert property (
    hi_vec_ff != VEC_NONE |-> $past(slot_type_ff) != 16'h0 ||
    $past(top_source_output_select_ff) == OUT_HIGH)
    else $error("High output used without high configuration.");

  AST_BUS_ANSWER: assert property (
    req && wait_ff && ce |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle.");

  AST_BUS_ONE_CYCLE: assert property (
    !avs_waitrequest && ce |=> avs_waitrequest)
    else $error("Bus answer stood longer than one cycle.");

  AST_RDATA_HOLDS: assert property (
    !(avs_read && wait_ff && ce) |=> $stable(avs_readdata))
    else $error("Read data changed without a read answer.");

  // Every present source has a table position, so pending always shows.
  AST_ANY_OUT: assert property (
    req_q_ff != 64'h0000_0000_0000_0000 |->
    irq_lo_ff || irq_hi_ff)
    else $error("Unmasked pending source drives no output.");

  // Every flop holds while the enable is low, the bus answer included.
  AST_CE_FREEZE: assert property (
    !$past(ce) && !$past(rst) |->
    $stable(pend_ff) && $stable(avs_waitrequest) &&
    $stable(lo_vec_ff) && $stable(hi_vec_ff) &&
    $stable(irq_lo_ff) && $stable(irq_hi_ff))
    else $error("State moved while the clock enable was low.");

  COV_TOP_LOW: cover property (
    irq_lo_ff && lo_vec_ff == top_q_ff);
  COV_HIGH: cover property (irq_hi_ff);
  COV_BOTH: cover property (irq_hi_ff && irq_lo_ff);
  COV_SPREAD: cover property (spread_ff != 4'h0 && irq_lo_ff);
  COV_CE_HOLD: cover property (!ce && irq_lo_ff);

endmodule : irq_prio_vec
`default_nettype wire

// ### sim/irq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// System-side sink for the two request lines
// ****************************************
module irq_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request lines from the block
  input wire logic irq_lo_ff,
  input wire logic irq_hi_ff,
  // Observed activity
  output var logic lo_seen_ff,
  output var logic hi_seen_ff
);
  // The two lines are taken as separate levels, never merged.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lo_seen_ff <= 1'b0;
      hi_seen_ff <= 1'b0;
    end else begin
      lo_seen_ff <= lo_seen_ff | irq_lo_ff;
      hi_seen_ff <= hi_seen_ff | irq_hi_ff;
    end
  end
endmodule : irq_host_model
`default_nettype wire

// ### sim/comm_engine_irq_priority_vector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module comm_engine_irq_priority_vector_tb
  import irq_prio_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [63:0] src_req = 64'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic irq_lo_ff;
  wire logic irq_hi_ff;
  wire logic [5:0] lo_vec_ff;
  wire logic [5:0] hi_vec_ff;
  wire logic lo_seen_ff;
  wire logic hi_seen_ff;
  int fails = 0;
  int checked = 0;
  int cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  irq_prio_vec dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .src_req(src_req), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_lo_ff(irq_lo_ff), .irq_hi_ff(irq_hi_ff), .lo_vec_ff(lo_vec_ff),
    .hi_vec_ff(hi_vec_ff));

  irq_host_model host_u (.clk_sys(clk_sys), .rst(rst),
    .irq_lo_ff(irq_lo_ff), .irq_hi_ff(irq_hi_ff),
    .lo_seen_ff(lo_seen_ff), .hi_seen_ff(hi_seen_ff));

  // ****************************************
  // Reporting
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // A hang in a bus wait is caught here rather than by the wait itself.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ****************************************
  // Bus and output helpers
  // ****************************************
  // Called just after a rising edge. The request stands until the edge at
  // which waitrequest is seen low; read data is taken at that same edge.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a,
    input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, q, exp);
  endtask : rd

  // Outputs trail a change by two edges; a third gives margin.
  task automatic outs(input logic lo, input logic hi, input logic [5:0] lv,
    input logic [5:0] hv);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq_lo", {31'h0, irq_lo_ff}, {31'h0, lo});
    chk("irq_hi", {31'h0, irq_hi_ff}, {31'h0, hi});
    chk("lo_vec", {26'h0, lo_vec_ff}, {26'h0, lv});
    chk("hi_vec", {26'h0, hi_vec_ff}, {26'h0, hv});
    @(posedge clk_sys);
  endtask : outs

  task automatic req(input logic [63:0] v);
    src_req <= v;
  endtask : req

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd("mask_lo", OFS_MASK_LO, 32'h0);
    rd("cfg", OFS_CFG, {26'h0, TOP_RST});
    rd("xmap", OFS_XMAP, {20'h0, MAP_RST});
    rd("ymap", OFS_YMAP, {20'h0, MAP_RST});
    rd("slot_type", OFS_SLOT_TYPE, 32'h0);
    rd("lo_vec_reg", OFS_LO_VEC, {26'h0, VEC_NONE});
    outs(1'b0, 1'b0, VEC_NONE, VEC_NONE);
  endtask : t_reset

  task automatic t_mask();
    req(64'h800);
    outs(1'b0, 1'b0, VEC_NONE, VEC_NONE);
    rd("pend_lo", OFS_PEND_LO, 32'h0000_0800);
    wr(OFS_MASK_LO, 32'h0000_0800);
    outs(1'b1, 1'b0, 6'h0B, VEC_NONE);
    rd("lo_vec_reg", OFS_LO_VEC, 32'h0000_000B);
    wr(OFS_LO_VEC, 32'h0000_0003);
    rd("lo_vec_ro", OFS_LO_VEC, 32'h0000_000B);
    wr(OFS_MASK_LO, 32'h0);
    outs(1'b0, 1'b0, VEC_NONE, VEC_NONE);
    rd("pend_held", OFS_PEND_LO, 32'h0000_0800);
    req(64'h0);
    wr(OFS_MASK_LO, 32'hFFFF_FFFF);
    wr(OFS_MASK_HI, 32'hFFFF_FFFF);
    rd("mask_lo_all", OFS_MASK_LO, SRC_PRESENT[31:0]);
    rd("mask_hi_all", OFS_MASK_HI, SRC_PRESENT[63:32]);
    rd("unmapped", 8'h40, 32'h0);
  endtask : t_mask

  task automatic t_prio();
    req(64'h402);
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
    req(64'h1000_0402);
    outs(1'b1, 1'b0, 6'h1C, VEC_NONE);
    req(64'h2_0000_0402);
    outs(1'b1, 1'b0, 6'h21, VEC_NONE);
    // Placement is only changed while no source is requesting.
    req(64'h0);
    wr(OFS_CFG, 32'h0000_011C);
    req(64'h2_0000_0400);
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
    req(64'h0);
    wr(OFS_CFG, 32'h0000_0F1C);
    req(64'h2_0000_0002);
    outs(1'b1, 1'b0, 6'h01, VEC_NONE);
    req(64'h0);
    wr(OFS_CFG, {26'h0, TOP_RST});
  endtask : t_prio

  task automatic t_top();
    req(64'h402);
    wr(OFS_CFG, 32'h0000_0001);
    outs(1'b1, 1'b0, 6'h01, VEC_NONE);
    wr(OFS_CFG, 32'h0002_0001);
    outs(1'b1, 1'b1, 6'h0A, 6'h01);
    chk("host_hi", {31'h0, hi_seen_ff}, 32'h1);
    chk("host_lo", {31'h0, lo_seen_ff}, 32'h1);
    rd("hi_vec_reg", OFS_HI_VEC, 32'h0000_0001);
    wr(OFS_CFG, 32'h0001_0001);
    outs(1'b1, 1'b0, 6'h01, VEC_NONE);
    wr(OFS_CFG, 32'h0003_0001);
    outs(1'b1, 1'b0, 6'h01, VEC_NONE);
    wr(OFS_CFG, {26'h0, TOP_RST});
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
  endtask : t_top

  task automatic t_type();
    req(64'h1400);
    wr(OFS_SLOT_TYPE, 32'h0000_0200);
    outs(1'b1, 1'b1, 6'h0C, 6'h0A);
    wr(OFS_SLOT_TYPE, 32'h0000_AAAA);
    outs(1'b1, 1'b1, 6'h0C, 6'h0A);
    wr(OFS_SLOT_TYPE, 32'h0000_0100);
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
    wr(OFS_SLOT_TYPE, 32'h0);
  endtask : t_type

  task automatic t_map();
    req(64'h3_0000_0000);
    outs(1'b1, 1'b0, 6'h20, VEC_NONE);
    rd("pend_hi", OFS_PEND_HI, 32'h0000_0003);
    wr(OFS_XMAP, 32'h0000_0681);
    outs(1'b1, 1'b0, 6'h21, VEC_NONE);
    rd("xmap_new", OFS_XMAP, 32'h0000_0681);
    wr(OFS_XMAP, {20'h0, MAP_RST});
    outs(1'b1, 1'b0, 6'h20, VEC_NONE);
    req(64'h500_0000_0000);
    outs(1'b1, 1'b0, 6'h28, VEC_NONE);
    wr(OFS_YMAP, 32'h0000_060A);
    outs(1'b1, 1'b0, 6'h2A, VEC_NONE);
    wr(OFS_YMAP, {20'h0, MAP_RST});
    req(64'h0);
    outs(1'b0, 1'b0, VEC_NONE, VEC_NONE);
  endtask : t_map

  // Clock enable low freezes the pending bits and the outputs.
  task automatic t_hold();
    req(64'h400);
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
    ce <= 1'b0;
    req(64'h800);
    outs(1'b1, 1'b0, 6'h0A, VEC_NONE);
    ce <= 1'b1;
    outs(1'b1, 1'b0, 6'h0B, VEC_NONE);
    req(64'h0);
  endtask : t_hold

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_mask();
    t_prio();
    t_top();
    t_type();
    t_map();
    t_hold();
    stop_test();
  end
endmodule : comm_engine_irq_priority_vector_tb
`default_nettype wire
